// >>> pkg/apm_pkg.sv
package apm_pkg;
   localparam int SYS_CLK_HZ  = 25_000_000;
   localparam int CONV_CLK_HZ = 1_560_000;
   localparam int CONV_DIV    = (SYS_CLK_HZ + CONV_CLK_HZ / 2) / CONV_CLK_HZ;
   localparam int CONV_BITS   = 12;
   localparam int CONV_CYCLES = CONV_DIV * CONV_BITS;
   localparam logic [3:0]  ADDR_FIXED   = 4'h5;
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [11:0] RESULT_RST   = 12'h000;
   localparam logic [2:0]  ADDR_CFG_RST = 3'h0;
   localparam int PD_LOW_BIT  = 0;
   localparam int PD_HIGH_BIT = 1;
   localparam int POL_BIT     = 2;
   localparam int RNG_BIT     = 3;
   localparam int CHAN_LSB    = 4;
   localparam logic [3:0] POL_BIT_CNT = 4'h5;
   localparam logic [3:0] BYTE_LAST   = 4'h7;
   localparam logic [3:0] ACK_CNT     = 4'h8;
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_RESULT   = 8'h04;
   localparam logic [7:0] REG_STATUS   = 8'h08;
   localparam logic [7:0] REG_ADDR_CFG = 8'h0c;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      PWR_NORMAL = 3'b001, PWR_STANDBY = 3'b010, PWR_FULL = 3'b100
   } apm_pwr_t;
   typedef enum logic [2:0] {
      CV_IDLE = 3'b001, CV_ACQ = 3'b010, CV_CONV = 3'b100
   } apm_cv_t;
   typedef enum logic [4:0] {
      LK_IDLE = 5'b00001, LK_ADDR = 5'b00010, LK_CTRL = 5'b00100,
      LK_TX = 5'b01000, LK_WAIT = 5'b10000
   } apm_lk_t;
endpackage

// >>> pkg/apm_link_if.sv
`timescale 1ns/1ps
interface apm_link_if;
   logic        wake;
   logic        acq_start;
   logic        stop_seen;
   logic        ctrl_valid;
   logic [7:0]  ctrl_byte;
   logic [11:0] result;
   logic [2:0]  addr_low;
   modport link (output wake, acq_start, stop_seen, ctrl_valid, ctrl_byte,
                 input result, addr_low);
   modport core (input wake, acq_start, stop_seen, ctrl_valid, ctrl_byte,
                 output result, addr_low);
endinterface

// >>> src/apm_link.sv
`timescale 1ns/1ps
module apm_link
   import apm_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_oe_n_o,
   apm_link_if.link  lnk
);
   logic       scl_m_q, scl_s_q, scl_p_q;
   logic       sda_m_q, sda_s_q, sda_p_q;
   apm_lk_t    lk_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic       rw_q, second_q, oe_n_q;
   logic       wake_q, acq_q, stop_q, cval_q;
   logic [7:0] ctrl_q;

   wire scl_rise = scl_s_q & ~scl_p_q;
   wire scl_fall = ~scl_s_q & scl_p_q;
   wire start_w  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   wire stop_w   = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
   wire bit8_w   = scl_rise & (cnt_q == BYTE_LAST);
   wire bend_w   = scl_rise & (cnt_q == ACK_CNT);
   wire [7:0] byte_w = {sh_q[6:0], sda_s_q};
   wire match_w  = byte_w[7:1] == {ADDR_FIXED, lnk.addr_low};
   wire [2:0] bit_sel_w = 3'(BYTE_LAST - cnt_q);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      end else begin
         {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      end
   end

   // Runs on the system clock whatever the power state
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lk_q     <= LK_IDLE;
         cnt_q    <= 4'h0;
         sh_q     <= 8'h00;
         tx_q     <= 8'h00;
         rw_q     <= 1'b0;
         second_q <= 1'b0;
         oe_n_q   <= 1'b1;
      end else if (start_w) begin
         lk_q   <= LK_ADDR;
         cnt_q  <= 4'h0;
         oe_n_q <= 1'b1;
      end else if (stop_w) begin
         lk_q   <= LK_IDLE;
         cnt_q  <= 4'h0;
         oe_n_q <= 1'b1;
      end else begin
         if (scl_rise) begin
            sh_q  <= byte_w;
            cnt_q <= bend_w ? 4'h0 : cnt_q + 4'h1;
         end
         case (lk_q)
            LK_ADDR: begin
               if (bit8_w) begin
                  rw_q <= sda_s_q;
                  if (!match_w) lk_q <= LK_WAIT;
               end
               if (bend_w) begin
                  lk_q     <= rw_q ? LK_TX : LK_CTRL;
                  tx_q     <= lnk.result[11:4];
                  second_q <= 1'b0;
               end
               if (scl_fall) oe_n_q <= cnt_q != ACK_CNT;
            end
            LK_CTRL: begin
               if (bend_w) lk_q <= LK_WAIT;
               if (scl_fall) oe_n_q <= cnt_q != ACK_CNT;
            end
            LK_TX: begin
               // Master acknowledge is ignored; exactly two bytes go out
               if (bend_w) begin
                  tx_q     <= {lnk.result[3:0], 4'h0};
                  second_q <= 1'b1;
                  if (second_q) lk_q <= LK_WAIT;
               end
               if (scl_fall) begin
                  oe_n_q <= (cnt_q == ACK_CNT) | tx_q[bit_sel_w];
               end
            end
            default: begin
               if (scl_fall) oe_n_q <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {wake_q, acq_q, stop_q, cval_q} <= 4'h0;
         ctrl_q <= 8'h00;
      end else begin
         wake_q <= bend_w & (lk_q == LK_ADDR) & ~rw_q;
         acq_q  <= scl_rise & (lk_q == LK_CTRL) & (cnt_q == POL_BIT_CNT);
         stop_q <= stop_w;
         cval_q <= bit8_w & (lk_q == LK_CTRL);
         if (bit8_w & (lk_q == LK_CTRL)) ctrl_q <= byte_w;
      end
   end

   assign sda_oe_n_o     = oe_n_q;
   assign lnk.wake       = wake_q;
   assign lnk.acq_start  = acq_q;
   assign lnk.stop_seen  = stop_q;
   assign lnk.ctrl_valid = cval_q;
   assign lnk.ctrl_byte  = ctrl_q;

   a_idle_release: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (lk_q == LK_IDLE) |-> oe_n_q)
      else $error("data line driven while idle");
endmodule // apm_link

// >>> src/apm_top.sv
`timescale 1ns/1ps
// Behaviour
// - Wakes in normal mode, idle, awaiting a start and own address.
// - Control byte and conversion result are zero after reset.
// - Two software low-power modes besides hardware shutdown: standby and full.
// - Power state follows the two power-down bits of the control byte.
// - Software power-down applies only after the running conversion ends.
// - Serial slave and result readback keep working in every power-down mode.
// - Wake needs a start plus matching address with write direction.
// - Powered operation resumes on the bit after the address byte.
// - Shutdown pin low forces full power-down at once, aborting conversion.
// - Standby keeps bandgap and reference buffer on.
// - Full power-down keeps only the bandgap on.
// - Standby chosen every byte powers down after each conversion, no restart delay.
// - Unipolar results are straight binary, full scale over 4096 steps.
// - Bipolar results are two's complement, twice full scale over 4096 steps.
// - High power-down bit 0 is normal; 10 standby; 11 full power-down.
// - Acquire from polarity bit latch until stop, then convert at once.
// - Conversion is timed by a 1.56MHz conversion clock, not the bus clock.
// - Reads send result bits 11..4, then 3..0 and four zeros.
module apm_top
   import apm_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o_o,
   output logic                   sda_oe_n_o,
   input  wire logic              hw_shutdown_n_i,
   input  wire logic [11:0]       raw_code_i,
   output logic                   bandgap_en_o,
   output logic                   refbuf_en_o,
   output logic                   core_en_o,
   output logic                   acq_o,
   output logic                   conv_busy_o,
   output logic [2:0]             chan_sel_o,
   output logic                   range_select_o,
   output logic                   polarity_select_o,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp
);
   localparam int conv_len_c = CONV_CYCLES;

   apm_link_if lnk ();

   apm_link u_link (
      .sys_clk_i  (sys_clk_i),
      .rst_b_i    (rst_b_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .sda_oe_n_o (sda_oe_n_o),
      .lnk        (lnk.link)
   );

   function automatic logic off_known(input logic [7:0] a);
      return (a == REG_CTRL) || (a == REG_RESULT) ||
             (a == REG_STATUS) || (a == REG_ADDR_CFG);
   endfunction

   function automatic logic [11:0] fmt_code(input logic [11:0] raw,
                                             input logic polarity_select);
      // Core code is offset binary; bipolar flips the sign bit
      return polarity_select ? {~raw[11], raw[10:0]} : raw;
   endfunction

   logic        sd_m_q, sd_s_q, hw_q;
   logic [7:0]  ctrl_q;
   logic [11:0] result_q;
   logic [2:0]  addr_cfg_q;
   apm_pwr_t    pwr_q, pwr_d;
   apm_cv_t     cv_q;
   logic [7:0]  cnt_q;

   // Shutdown pin is asynchronous to this clock
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sd_m_q <= 1'b1;
         sd_s_q <= 1'b1;
         hw_q   <= 1'b0;
      end else begin
         sd_m_q <= hw_shutdown_n_i;
         sd_s_q <= sd_m_q;
         hw_q   <= ~sd_s_q;
      end
   end

   wire pd_high_w = ctrl_q[PD_HIGH_BIT];
   wire pd_low_w  = ctrl_q[PD_LOW_BIT];
   wire cv_last_w = cnt_q == 8'(CONV_CYCLES - 1);
   wire done_w    = (cv_q == CV_CONV) & cv_last_w & sd_s_q;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= CTRL_RST;
      end else if (lnk.ctrl_valid) begin
         ctrl_q <= lnk.ctrl_byte;
      end
   end

   // Conversion sequencer
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cv_q  <= CV_IDLE;
         cnt_q <= 8'h00;
      end else if (!sd_s_q) begin
         cv_q  <= CV_IDLE;
         cnt_q <= 8'h00;
      end else begin
         case (cv_q)
            CV_IDLE: begin
               if (lnk.acq_start) cv_q <= CV_ACQ;
            end
            CV_ACQ: begin
               if (lnk.stop_seen) begin
                  cv_q  <= CV_CONV;
                  cnt_q <= 8'h00;
               end
            end
            CV_CONV: begin
               // One count per system clock; CONV_DIV counts make one conversion-clock period
               cnt_q <= cnt_q + 8'h01;
               if (cv_last_w) cv_q <= CV_IDLE;
            end
            default: cv_q <= CV_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_q <= RESULT_RST;
      end else if (done_w) begin
         result_q <= fmt_code(raw_code_i, ctrl_q[POL_BIT]);
      end
   end

   // Power state; a conversion start also forces power on
   always_comb begin
      pwr_d = pwr_q;
      if (!sd_s_q) begin
         pwr_d = PWR_FULL;
      end else if (lnk.wake | lnk.acq_start) begin
         pwr_d = PWR_NORMAL;
      end else if (done_w & pd_high_w) begin
         pwr_d = pd_low_w ? PWR_FULL : PWR_STANDBY;
      end else if (hw_q) begin
         pwr_d = PWR_NORMAL;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pwr_q <= PWR_NORMAL;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   // Bandgap never switches off; only the pin-level supply removes it
   assign bandgap_en_o      = 1'b1;
   assign refbuf_en_o       = pwr_q != PWR_FULL;
   assign core_en_o         = pwr_q == PWR_NORMAL;
   assign acq_o             = cv_q == CV_ACQ;
   assign conv_busy_o       = cv_q == CV_CONV;
   assign chan_sel_o        = ctrl_q[CHAN_LSB +: 3];
   assign range_select_o    = ctrl_q[RNG_BIT];
   assign polarity_select_o = ctrl_q[POL_BIT];
   assign sda_o_o           = 1'b0;
   assign lnk.result        = result_q;
   assign lnk.addr_low      = addr_cfg_q;

   // Register slave
   logic [7:0]  aw_q;
   logic        aw_ok_q, w_ok_q, bvalid_q, rvalid_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;

   wire aw_hs_w  = s_axi_awvalid & s_axi_awready;
   wire w_hs_w   = s_axi_wvalid & s_axi_wready;
   wire ar_hs_w  = s_axi_arvalid & s_axi_arready;
   wire do_wr_w  = aw_ok_q & w_ok_q & ~bvalid_q;
   wire [7:0] ar_off_w = s_axi_araddr[7:0];
   wire [31:0] status_w = {26'h0, hw_q, ~sd_s_q, cv_q == CV_CONV,
                           pwr_q};
   wire [31:0] rd_mux_w =
      (ar_off_w == REG_CTRL)     ? {24'h0, ctrl_q} :
      (ar_off_w == REG_RESULT)   ? {20'h0, result_q} :
      (ar_off_w == REG_STATUS)   ? status_w :
      (ar_off_w == REG_ADDR_CFG) ? {29'h0, addr_cfg_q} : 32'h0;

   assign s_axi_awready = ~aw_ok_q & ~bvalid_q;
   assign s_axi_wready  = ~w_ok_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_q    <= 8'h00;
         aw_ok_q <= 1'b0;
         w_ok_q  <= 1'b0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_hs_w) begin
            aw_q    <= s_axi_awaddr[7:0];
            aw_ok_q <= 1'b1;
         end else if (do_wr_w) begin
            aw_ok_q <= 1'b0;
         end
         if (w_hs_w) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_ok_q  <= 1'b1;
         end else if (do_wr_w) begin
            w_ok_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bvalid_q   <= 1'b0;
         bresp_q    <= RESP_OKAY;
         addr_cfg_q <= ADDR_CFG_RST;
      end else if (do_wr_w) begin
         bvalid_q <= 1'b1;
         bresp_q  <= off_known(aw_q) ? RESP_OKAY : RESP_SLVERR;
         if ((aw_q == REG_ADDR_CFG) && wstrb_q[0]) addr_cfg_q <= wdata_q[2:0];
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= RESP_OKAY;
      end else if (ar_hs_w) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux_w;
         rresp_q  <= off_known(ar_off_w) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   a_hw_shutdown_n_forces_full: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !sd_s_q |=> (pwr_q == PWR_FULL) && (cv_q == CV_IDLE))
      else $error("shutdown did not force full power-down");

   a_hw_shutdown_n_no_start: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (!sd_s_q ##1 !sd_s_q) |-> (cv_q == CV_IDLE) && (pwr_q == PWR_FULL))
      else $error("activity while shutdown held");

   a_standby_refs: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (pwr_q == PWR_STANDBY) |-> refbuf_en_o && bandgap_en_o && !core_en_o)
      else $error("standby reference state wrong");

   a_full_refs: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (pwr_q == PWR_FULL) |-> !refbuf_en_o && bandgap_en_o)
      else $error("full power-down reference state wrong");

   a_pd_after_conv: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (cv_q != CV_IDLE) && sd_s_q && !hw_q |-> pwr_q == PWR_NORMAL)
      else $error("powered down during conversion");

   a_pd_decode: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_w && !lnk.wake && !lnk.acq_start |=>
         pwr_q == (!$past(pd_high_w) ? $past(pwr_q) :
                   $past(pd_low_w) ? PWR_FULL : PWR_STANDBY))
      else $error("power-down field decoded wrongly");

   a_conv_length: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (cv_q == CV_ACQ) && lnk.stop_seen && sd_s_q |->
         ##[conv_len_c:conv_len_c] (done_w || !sd_s_q || hw_q))
      else $error("conversion length wrong");

   a_stop_converts: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (cv_q == CV_ACQ) && lnk.stop_seen && sd_s_q |=> cv_q == CV_CONV)
      else $error("stop did not start conversion");

   a_wake_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      lnk.wake && sd_s_q |=> pwr_q == PWR_NORMAL)
      else $error("addressed write did not wake");

   a_result_code: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      done_w |=> result_q == ($past(ctrl_q[POL_BIT]) ?
                  {~$past(raw_code_i[11]), $past(raw_code_i[10:0])} :
                  $past(raw_code_i)))
      else $error("result coding wrong");
endmodule // apm_top

// >>> tb/apm_tw_master.sv
`timescale 1ns/1ps
// Two-wire bus master; clock stands high between frames, data is open drain
module apm_tw_master (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Quarter of the 320 ns bus period
   task automatic q();
      repeat (2) @(posedge clk_i);
   endtask
   task automatic start_c();
      sda_low_o <= 1'b1;
      q();
      scl_o <= 1'b0;
      q();
   endtask
   task automatic stop_c();
      sda_low_o <= 1'b1;
      q();
      scl_o <= 1'b1;
      q();
      sda_low_o <= 1'b0;
      q();
      q();
   endtask
   // Data changes only while the clock is low; sampled late in the high phase
   task automatic bit_c(input logic b, output logic r);
      sda_low_o <= !b;
      q();
      scl_o <= 1'b1;
      q();
      q();
      r = sda_i;
      scl_o <= 1'b0;
      q();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_c(d[i], r);
      bit_c(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, r);
         d[i] = r;
      end
      bit_c(!mack, r);
   endtask
endmodule // apm_tw_master

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import apm_pkg::*;
   localparam logic [1:0] PD_TAB [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2, 2'h0, 2'h3};
   logic        clk, rst_b, hw_shutdown_n_n, scl, m_low, sda_oe_n, bg, rb, core, acq, busy, range_select, pol;
   logic        sda_o;
   wire         sda;
   logic [11:0] raw;
   logic [2:0]  chan;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [15:0] lfsr_q;
   int          error_cnt, n_checks;
   int          exp_q[$];
   // Pull-up: the line is low if either party pulls it
   assign sda = !(m_low || !sda_oe_n);
   apm_tw_master u_mst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
   apm_top u_dut (
      .sys_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda), .sda_o_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .hw_shutdown_n_i(hw_shutdown_n_n), .raw_code_i(raw),
      .bandgap_en_o(bg), .refbuf_en_o(rb), .core_en_o(core), .acq_o(acq),
      .conv_busy_o(busy), .chan_sel_o(chan), .range_select_o(range_select), .polarity_select_o(pol),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic test_done();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic tmo(input string m);
      error_cnt++;
      $display("MISMATCH %0t timeout %s", $time, m);
      test_done();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_d, w_d;
      int   n;
      aw_d = 1'b0;
      w_d = 1'b0;
      n = 0;
      {awvalid, wvalid, bready} <= 3'b111;
      awaddr <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         if (awready) aw_d = 1'b1;
         if (wready) w_d = 1'b1;
         if (aw_d) awvalid <= 1'b0;
         if (w_d) wvalid <= 1'b0;
         if (n++ > 50) tmo("aw");
      end while (!(aw_d && w_d));
      do begin
         @(posedge clk);
         if (n++ > 100) tmo("b");
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      {arvalid, rready} <= 2'b11;
      araddr <= a;
      do begin
         @(posedge clk);
         if (n++ > 50) tmo("ar");
      end while (!arready);
      arvalid <= 1'b0;
      do begin
         @(posedge clk);
         if (n++ > 100) tmo("r");
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string s);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(d & m, e, s);
      chk(r, RESP_OKAY, s);
   endtask
   task automatic tw_write(input logic [7:0] c, input logic up);
      logic k, k2;
      u_mst.start_c();
      u_mst.wbyte(8'h56, k);
      chk({k, core}, {1'b1, up}, "wake");
      u_mst.wbyte(c, k2);
      chk(acq, up, "acquire");
      u_mst.stop_c();
   endtask
   task automatic tw_read(output logic [15:0] d);
      logic k;
      u_mst.start_c();
      u_mst.wbyte(8'h57, k);
      u_mst.rbyte(1'b1, d[15:8]);
      u_mst.rbyte(1'b0, d[7:0]);
      u_mst.stop_c();
   endtask
   task automatic conv_wait();
      int n;
      n = 0;
      while (!busy) begin
         cyc(1);
         if (n++ > 12) tmo("start");
      end
      n = 0;
      while (busy) begin
         if (n == 100) chk(core, 1'b1, "busy power");
         cyc(1);
         if (n++ > 400) tmo("conv");
      end
      chk(n, CONV_CYCLES, "conv length");
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      tmo("run");
   end
   initial begin
      logic [1:0]  r, pd;
      logic [31:0] d;
      logic [7:0]  c;
      logic [15:0] rd;
      logic        k, seen;
      int          er;
      {rst_b, hw_shutdown_n_n, raw, awaddr, araddr, wdata} = {2'b01, 60'h0};
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {error_cnt, n_checks, lfsr_q} = {32'h0, 32'h0, 16'h0002};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      // Two-stage sync on the bus pins needs a few edges before a start
      cyc(4);
      chk({core, rb, bg, sda_oe_n, sda_o}, 5'h1e, "reset pins");
      rchk(REG_CTRL, 32'hff, 32'h0, "ctrl reset");
      rchk(REG_RESULT, 32'hfff, 32'h0, "result reset");
      rchk(REG_STATUS, 32'h3f, 32'h1, "power reset");
      axi_rd(8'h10, d, r);
      chk(r, RESP_SLVERR, "unmapped read");
      chk(d, 32'h0, "unmapped read data");
      axi_wr(8'h20, 32'h0, r);
      chk(r, RESP_SLVERR, "unmapped write");
      axi_wr(REG_ADDR_CFG, 32'h3, r);
      rchk(REG_ADDR_CFG, 32'h7, 32'h3, "addr cfg");
      for (int i = 0; i < 8; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         pd = PD_TAB[i];
         c = {1'b0, lfsr_q[14:12], lfsr_q[15], i[0], pd};
         raw <= lfsr_q[11:0];
         er = i[0] ? (int'(lfsr_q[11:0]) - 2048) & 4095 : int'(lfsr_q[11:0]);
         exp_q.push_back(er);
         tw_write(c, 1'b1);
         conv_wait();
         cyc(2);
         chk(core, !pd[1], "core enable");
         chk({bg, rb}, {1'b1, pd != 2'h3}, "reference enables");
         chk({chan, range_select, pol}, c[6:2], "fields");
         rchk(REG_STATUS, 32'hf, pd[1] ? (pd[0] ? 32'h4 : 32'h2) : 32'h1, "power");
         rchk(REG_CTRL, 32'hff, c, "ctrl");
         rchk(REG_RESULT, 32'hfff, er, "result");
         tw_read(rd);
         chk(rd, {er[11:0], 4'h0}, "serial read");
         chk(core, !pd[1], "read keeps state");
      end
      u_mst.start_c();
      u_mst.wbyte(8'h50, k);
      u_mst.stop_c();
      chk({k, core}, 2'b00, "foreign address");
      tw_write(8'h00, 1'b1);
      cyc(40);
      chk(busy, 1'b1, "busy before shutdown");
      rchk(REG_STATUS, 32'hf, 32'h9, "running status");
      hw_shutdown_n_n <= 1'b0;
      cyc(5);
      chk({busy, core, rb}, 3'b000, "shutdown");
      rchk(REG_RESULT, 32'hfff, exp_q[$], "abort keeps result");
      tw_write(8'h00, 1'b0);
      seen = 1'b0;
      repeat (30) begin
         cyc(1);
         seen = seen | busy;
      end
      chk({seen, core}, 2'b00, "held down");
      rchk(REG_STATUS, 32'h3f, 32'h34, "held full");
      hw_shutdown_n_n <= 1'b1;
      cyc(6);
      chk(core, 1'b1, "shutdown release");
      test_done();
   end
endmodule // tb_top
